// ### rtl/motor_fault_protection.sv
// motor fault protection: fault flags, enable mask, active word, debounce, bus filter
// assumes all inputs except the trip pin and comparators are synchronous to clk_i
`timescale 1ns/10ps
// Notes on behaviour
// - trip pin is active low; low level means over-current.
// - over-current source selectable: pin, comparators, or both.
// - any over-current sets flag bit 0; pin source also sets bit 5.
// - single shunt uses one comparator, leg shunt uses three at one trip level.
// - debounce counts while input asserted, clears when input drops.
// - count reaching filter time asserts trap at once; PWM goes passive.
// - gate-kill fault stays latched until software writes one to fault clear.
// - gate-kill fault is unmaskable and always requests fault state.
// - filter time in cycles, range 4 to 960, default 96.
// - over-temperature when thermistor voltage below shutdown threshold.
// - enable bit 6 decides if over-temperature forces fault state.
// - bus voltage sampled per PWM cycle, low-pass weight 2^11 of 2^16, readable.
// - filtered bus above over-voltage sets bit 2, masked by enable bit 2.
// - filtered bus below under-voltage sets bit 3, masked by enable bit 3.
// - above critical level motor stops, zero vector until cleared; unmaskable.
// - at parking end, any phase current below level confirms phase loss.
// - phase loss reaches active word and fault state only with enable bit 8.
// - offset out of range sets bit 9; cleared by fault clear in fault state.
// - enabled offset fault goes to fault state, else motor goes to stop.
// - offset limits are 12-bit adc counts, full scale 4095.
module motor_fault_protection
  import fault_prot_pkg::*;
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  // register port
  input  wire logic [3:0]        addr_i,
  input  wire logic [15:0]       wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [15:0]       rdata_o,
  // over-current sources
  input  wire logic              overcurrent_trip_pin_n_i,
  input  wire logic [2:0]        comparator_trip_i,
  // measurements
  input  wire logic              pwm_cycle_i,
  input  wire logic [15:0]       bus_voltage_i,
  input  wire logic [11:0]       thermistor_voltage_i,
  input  wire logic              parking_end_i,
  input  wire logic [11:0]       phase_current_a_i,
  input  wire logic [11:0]       phase_current_b_i,
  input  wire logic [11:0]       phase_current_c_i,
  input  wire logic              offset_done_i,
  input  wire logic [11:0]       offset_a_i,
  input  wire logic [11:0]       offset_b_i,
  input  wire logic [11:0]       offset_c_i,
  input  wire logic              motor_in_fault_i,
  // protection outputs
  output logic                   pwm_trap_o,
  output logic                   zero_vector_o,
  output logic                   fault_state_req_o,
  output logic                   stop_state_req_o,
  output logic [11:0]            comparator_trip_level_o
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic out_of_range(input logic [11:0] v, input logic [11:0] lo,
                                        input logic [11:0] hi);
    out_of_range = (v < lo) || (v > hi);
  endfunction : out_of_range

  function automatic logic [11:0] adc_clip(input logic [15:0] v);
    adc_clip = (v > {4'h0, ADC_FULL}) ? ADC_FULL : v[11:0];
  endfunction : adc_clip

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [FLT_W-1:0] fault_flag_word_reg;
  logic [FLT_W-1:0] fault_enable_mask_reg;
  logic [FLT_W-1:0] active_fault_word;
  logic [15:0]      config_reg;
  logic [9:0]       trip_debounce_cycles_reg;
  logic [11:0]      comparator_trip_level_reg;
  logic [15:0]      bus_overvoltage_level_reg;
  logic [15:0]      bus_undervoltage_level_reg;
  logic [15:0]      bus_critical_level_reg;
  logic [11:0]      shutdown_level_reg;
  logic [11:0]      open_phase_current_level_reg;
  logic [11:0]      offset_upper_limit_reg;
  logic [11:0]      offset_lower_limit_reg;
  logic [ACC_W-1:0] vbus_acc_reg;
  logic [15:0]      bus_voltage_filtered;
  logic             clear_cmd;

  assign clear_cmd = wr_i && (addr_i == ADR_CLEAR) && wdata_i[0];

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fault_enable_mask_reg        <= ENABLE_RST;
      config_reg                   <= CONFIG_RST;
      trip_debounce_cycles_reg     <= DEBOUNCE_RST;
      comparator_trip_level_reg    <= 12'h0_FFF;
      bus_overvoltage_level_reg    <= 16'hFFFF;
      bus_undervoltage_level_reg   <= 16'h0000;
      bus_critical_level_reg       <= 16'hFFFF;
      shutdown_level_reg           <= 12'h0_000;
      open_phase_current_level_reg <= 12'h0_000;
      offset_upper_limit_reg       <= ADC_FULL;
      offset_lower_limit_reg       <= 12'h0_000;
    end else if (wr_i) begin
      unique case (addr_i)
        ADR_ENABLE:   fault_enable_mask_reg <= wdata_i;
        ADR_CONFIG:   config_reg <= wdata_i;
        ADR_DEBOUNCE: begin
          if (wdata_i < {6'h00, DEBOUNCE_MIN}) begin
            trip_debounce_cycles_reg <= DEBOUNCE_MIN;
          end else if (wdata_i > {6'h00, DEBOUNCE_MAX}) begin
            trip_debounce_cycles_reg <= DEBOUNCE_MAX;
          end else begin
            trip_debounce_cycles_reg <= wdata_i[9:0];
          end
        end
        ADR_CMPLVL:   comparator_trip_level_reg <= adc_clip(wdata_i);
        ADR_OVLVL:    bus_overvoltage_level_reg <= wdata_i;
        ADR_UVLVL:    bus_undervoltage_level_reg <= wdata_i;
        ADR_CRITLVL:  bus_critical_level_reg <= wdata_i;
        ADR_OTLVL:    shutdown_level_reg <= adc_clip(wdata_i);
        ADR_PLLVL:    open_phase_current_level_reg <= adc_clip(wdata_i);
        ADR_OFSMAX:   offset_upper_limit_reg <= adc_clip(wdata_i);
        ADR_OFSMIN:   offset_lower_limit_reg <= adc_clip(wdata_i);
        default: ;
      endcase
    end
  end

  assign comparator_trip_level_o = comparator_trip_level_reg;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [3:0] oc_meta_reg;
  logic [3:0] oc_sync_reg;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      oc_meta_reg <= 4'h1;
      oc_sync_reg <= 4'h1;
    end else begin
      oc_meta_reg <= {comparator_trip_i, overcurrent_trip_pin_n_i};
      oc_sync_reg <= oc_meta_reg;
    end
  end

  // ----------------------------------------
  // over-current source select and debounce
  // ----------------------------------------
  logic       pin_trip;
  logic       cmp_trip;
  logic       oc_level;
  logic [9:0] deb_cnt_reg;
  logic       deb_hit;
  logic       pin_seen_reg;

  assign pin_trip = config_reg[CFG_PIN_EN_BIT] && !oc_sync_reg[0];
  assign cmp_trip = config_reg[CFG_CMP_EN_BIT] &&
                    (config_reg[CFG_LEG_BIT] ? |oc_sync_reg[3:1] : oc_sync_reg[1]);
  assign oc_level = pin_trip || cmp_trip;
  assign deb_hit  = oc_level && (deb_cnt_reg + 10'h001 >= trip_debounce_cycles_reg);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      deb_cnt_reg  <= 10'h000;
      pin_seen_reg <= 1'b0;
    end else if (!oc_level) begin
      deb_cnt_reg  <= 10'h000;
      pin_seen_reg <= 1'b0;
    end else begin
      pin_seen_reg <= pin_seen_reg || pin_trip;
      if (!deb_hit) begin
        deb_cnt_reg <= deb_cnt_reg + 10'h001;
      end
    end
  end

  // ----------------------------------------
  // bus voltage filter
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      vbus_acc_reg <= '0;
    end else if (pwm_cycle_i) begin
      // acc += (sample - acc) * 2^11 / 2^16
      vbus_acc_reg <= vbus_acc_reg - (vbus_acc_reg >> VFILT_SHIFT)
                      + ({16'h0000, bus_voltage_i} << (16 - VFILT_SHIFT));
    end
  end

  assign bus_voltage_filtered = vbus_acc_reg[ACC_W-1:16];

  // ----------------------------------------
  // fault detection and flag word
  // ----------------------------------------
  logic [FLT_W-1:0] set_vec;
  logic             pl_now;
  logic             ofs_now;

  assign pl_now  = parking_end_i && ((phase_current_a_i < open_phase_current_level_reg) ||
                   (phase_current_b_i < open_phase_current_level_reg) ||
                   (phase_current_c_i < open_phase_current_level_reg));
  assign ofs_now = offset_done_i &&
    (out_of_range(offset_a_i, offset_lower_limit_reg, offset_upper_limit_reg) ||
     out_of_range(offset_b_i, offset_lower_limit_reg, offset_upper_limit_reg) ||
     out_of_range(offset_c_i, offset_lower_limit_reg, offset_upper_limit_reg));

  always_comb begin
    set_vec                = '0;
    set_vec[FLT_OC_BIT]    = deb_hit;
    set_vec[FLT_PIN_BIT]   = deb_hit && (pin_seen_reg || pin_trip);
    set_vec[FLT_OV_BIT]    = bus_voltage_filtered > bus_overvoltage_level_reg;
    set_vec[FLT_UV_BIT]    = bus_voltage_filtered < bus_undervoltage_level_reg;
    set_vec[FLT_OT_BIT]    = thermistor_voltage_i < shutdown_level_reg;
    set_vec[FLT_PL_BIT]    = pl_now;
    set_vec[FLT_OFS_BIT]   = ofs_now;
    set_vec[FLT_CRIT_BIT]  = bus_voltage_filtered > bus_critical_level_reg;
  end

  // set wins over clear; offset flag clears only while in fault state
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fault_flag_word_reg <= '0;
    end else begin
      for (int i = 0; i < FLT_W; i++) begin
        if (set_vec[i]) begin
          fault_flag_word_reg[i] <= 1'b1;
        end else if (clear_cmd && (i != FLT_OFS_BIT || motor_in_fault_i)) begin
          fault_flag_word_reg[i] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // active word and state requests
  // ----------------------------------------
  logic [FLT_W-1:0] unmaskable;

  always_comb begin
    unmaskable               = '0;
    unmaskable[FLT_OC_BIT]   = 1'b1;
    unmaskable[FLT_PIN_BIT]  = 1'b1;
    unmaskable[FLT_CRIT_BIT] = 1'b1;
  end

  assign active_fault_word = fault_flag_word_reg & (fault_enable_mask_reg | unmaskable);
  assign fault_state_req_o = |active_fault_word;
  assign stop_state_req_o  = fault_flag_word_reg[FLT_OFS_BIT] &&
                             !fault_enable_mask_reg[FLT_OFS_BIT];
  assign pwm_trap_o        = fault_flag_word_reg[FLT_OC_BIT];
  assign zero_vector_o     = fault_flag_word_reg[FLT_CRIT_BIT];

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      unique case (addr_i)
        ADR_FLAGS:    rdata_o <= fault_flag_word_reg;
        ADR_ENABLE:   rdata_o <= fault_enable_mask_reg;
        ADR_ACTIVE:   rdata_o <= active_fault_word;
        ADR_CLEAR:    rdata_o <= 16'h0000;
        ADR_CONFIG:   rdata_o <= config_reg;
        ADR_DEBOUNCE: rdata_o <= {6'h00, trip_debounce_cycles_reg};
        ADR_CMPLVL:   rdata_o <= {4'h0, comparator_trip_level_reg};
        ADR_VBUS:     rdata_o <= bus_voltage_filtered;
        ADR_OVLVL:    rdata_o <= bus_overvoltage_level_reg;
        ADR_UVLVL:    rdata_o <= bus_undervoltage_level_reg;
        ADR_CRITLVL:  rdata_o <= bus_critical_level_reg;
        ADR_OTLVL:    rdata_o <= {4'h0, shutdown_level_reg};
        ADR_PLLVL:    rdata_o <= {4'h0, open_phase_current_level_reg};
        ADR_OFSMAX:   rdata_o <= {4'h0, offset_upper_limit_reg};
        ADR_OFSMIN:   rdata_o <= {4'h0, offset_lower_limit_reg};
        ADR_STATE:    rdata_o <= {12'h000, stop_state_req_o, zero_vector_o,
                                  pwm_trap_o, fault_state_req_o};
        default:      rdata_o <= 16'h0000;
      endcase
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_trap_latched;
    @(posedge clk_i) disable iff (!rstn_i)
      (pwm_trap_o && !(clear_cmd && !deb_hit)) |=> pwm_trap_o;
  endproperty
  a_trap_latched: assert property (p_trap_latched) else $error("trap dropped");

  property p_deb_trip;
    @(posedge clk_i) disable iff (!rstn_i)
      deb_hit |=> fault_flag_word_reg[FLT_OC_BIT] && fault_state_req_o;
  endproperty
  a_deb_trip: assert property (p_deb_trip) else $error("trip not flagged");

  property p_deb_reset;
    @(posedge clk_i) disable iff (!rstn_i)
      !oc_level |=> deb_cnt_reg == 10'h000;
  endproperty
  a_deb_reset: assert property (p_deb_reset) else $error("debounce not cleared");

  property p_deb_range;
    @(posedge clk_i) disable iff (!rstn_i)
      trip_debounce_cycles_reg >= DEBOUNCE_MIN && trip_debounce_cycles_reg <= DEBOUNCE_MAX;
  endproperty
  a_deb_range: assert property (p_deb_range) else $error("filter time range");

  property p_pin_bit;
    @(posedge clk_i) disable iff (!rstn_i)
      $rose(fault_flag_word_reg[FLT_PIN_BIT]) |-> fault_flag_word_reg[FLT_OC_BIT];
  endproperty
  a_pin_bit: assert property (p_pin_bit) else $error("pin bit without oc");

  property p_ot_masked;
    @(posedge clk_i) disable iff (!rstn_i)
      (fault_flag_word_reg == (16'h0001 << FLT_OT_BIT)) |->
        fault_state_req_o == fault_enable_mask_reg[FLT_OT_BIT];
  endproperty
  a_ot_masked: assert property (p_ot_masked) else $error("ot mask");

  property p_ov_set;
    @(posedge clk_i) disable iff (!rstn_i)
      (bus_voltage_filtered > bus_overvoltage_level_reg) |=> fault_flag_word_reg[FLT_OV_BIT];
  endproperty
  a_ov_set: assert property (p_ov_set) else $error("ov not set");

  property p_uv_set;
    @(posedge clk_i) disable iff (!rstn_i)
      (bus_voltage_filtered < bus_undervoltage_level_reg) |=> fault_flag_word_reg[FLT_UV_BIT];
  endproperty
  a_uv_set: assert property (p_uv_set) else $error("uv not set");

  property p_crit;
    @(posedge clk_i) disable iff (!rstn_i)
      zero_vector_o |-> fault_state_req_o;
  endproperty
  a_crit: assert property (p_crit) else $error("critical not forcing");

  property p_ofs_hold;
    @(posedge clk_i) disable iff (!rstn_i)
      (fault_flag_word_reg[FLT_OFS_BIT] && !motor_in_fault_i) |=>
        fault_flag_word_reg[FLT_OFS_BIT];
  endproperty
  a_ofs_hold: assert property (p_ofs_hold) else $error("offset flag lost");

  property p_pl_mask;
    @(posedge clk_i) disable iff (!rstn_i)
      active_fault_word[FLT_PL_BIT] |->
        fault_enable_mask_reg[FLT_PL_BIT] && fault_state_req_o;
  endproperty
  a_pl_mask: assert property (p_pl_mask) else $error("phase loss mask");

  property p_pl_set;
    @(posedge clk_i) disable iff (!rstn_i)
      pl_now |=> fault_flag_word_reg[FLT_PL_BIT];
  endproperty
  a_pl_set: assert property (p_pl_set) else $error("phase loss not flagged");

  property p_ofs_set;
    @(posedge clk_i) disable iff (!rstn_i)
      ofs_now |=> fault_flag_word_reg[FLT_OFS_BIT];
  endproperty
  a_ofs_set: assert property (p_ofs_set) else $error("offset fault not flagged");

endmodule : motor_fault_protection

// ### rtl/fault_prot_pkg.sv
// package for the motor fault protection block: field positions, reset values, widths
// assumes a single 20 MHz clock domain
package fault_prot_pkg;
  // ----------------------------------------
  // fault word bit positions
  // ----------------------------------------
  localparam int unsigned FLT_OC_BIT      = 0;
  localparam int unsigned FLT_OV_BIT      = 2;
  localparam int unsigned FLT_UV_BIT      = 3;
  localparam int unsigned FLT_PIN_BIT     = 5;
  localparam int unsigned FLT_OT_BIT      = 6;
  localparam int unsigned FLT_PL_BIT      = 8;
  localparam int unsigned FLT_OFS_BIT     = 9;
  localparam int unsigned FLT_CRIT_BIT    = 10;
  localparam int unsigned FLT_W           = 16;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [3:0] ADR_FLAGS     = 4'h0;
  localparam logic [3:0] ADR_ENABLE    = 4'h1;
  localparam logic [3:0] ADR_ACTIVE    = 4'h2;
  localparam logic [3:0] ADR_CLEAR     = 4'h3;
  localparam logic [3:0] ADR_CONFIG    = 4'h4;
  localparam logic [3:0] ADR_DEBOUNCE  = 4'h5;
  localparam logic [3:0] ADR_CMPLVL    = 4'h6;
  localparam logic [3:0] ADR_VBUS      = 4'h7;
  localparam logic [3:0] ADR_OVLVL     = 4'h8;
  localparam logic [3:0] ADR_UVLVL     = 4'h9;
  localparam logic [3:0] ADR_CRITLVL   = 4'hA;
  localparam logic [3:0] ADR_OTLVL     = 4'hB;
  localparam logic [3:0] ADR_PLLVL     = 4'hC;
  localparam logic [3:0] ADR_OFSMAX    = 4'hD;
  localparam logic [3:0] ADR_OFSMIN    = 4'hE;
  localparam logic [3:0] ADR_STATE     = 4'hF;
  // ----------------------------------------
  // config fields and reset values
  // ----------------------------------------
  localparam int unsigned CFG_PIN_EN_BIT  = 0;
  localparam int unsigned CFG_CMP_EN_BIT  = 1;
  localparam int unsigned CFG_LEG_BIT     = 2;
  localparam logic [15:0] CONFIG_RST      = 16'h0003;
  localparam logic [15:0] ENABLE_RST      = 16'h034C;
  localparam logic [9:0]  DEBOUNCE_MIN    = 10'h004;
  localparam logic [9:0]  DEBOUNCE_MAX    = 10'h3C0;
  localparam logic [9:0]  DEBOUNCE_RST    = 10'h060;
  localparam logic [11:0] ADC_FULL        = 12'hFFF;
  localparam logic [15:0] VFILT_SHIFT     = 16'h0005; // 2^11 / 2^16
  localparam int unsigned VBUS_W          = 16;
  localparam int unsigned ACC_W           = 32;
endpackage : fault_prot_pkg

// ### sim/fault_partner.sv
// partner model: external trip circuit and motor state machine around the protection block
// assumes one clock shared with the block; the bench asks for trips through trip_req_i
`timescale 1ns/10ps
module fault_partner (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // bench side
  input  wire logic trip_req_i,
  // block side
  input  wire logic fault_state_req_i,
  output logic      overcurrent_trip_pin_n_o,
  output logic      motor_in_fault_o
);
  // ----------------------------------------
  // trip circuit pulls the pin low
  // ----------------------------------------
  assign overcurrent_trip_pin_n_o = ~trip_req_i;
  // ----------------------------------------
  // state machine follows the fault request
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      motor_in_fault_o <= 1'b0;
    end else begin
      motor_in_fault_o <= fault_state_req_i;
    end
  end
endmodule : fault_partner

// ### sim/motor_fault_protection_test.sv
// testbench for the motor fault protection block
// assumes the partner model and the design package are compiled first
`timescale 1ns/10ps
`define CHK(nm, e, g) tests_run++; if ((g) !== (e)) begin err_total++; $display("BAD %s exp %h got %h", nm, e, g); end
module motor_fault_protection_test;
  import fault_prot_pkg::*;
  typedef struct packed {logic [3:0] a; logic [15:0] rv; logic [15:0] wd; logic [15:0] ex;} reg_row_t;
  typedef struct packed {logic [15:0] cfg; logic pin; logic [2:0] cmp; logic [15:0] ex;} trip_row_t;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        clk_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0, trip_req = 0;
  logic [3:0]  addr_i = 0;
  logic [15:0] wdata_i = 0, rdata_o, bus_voltage_i = 0, rv;
  logic [2:0]  comparator_trip_i = 0;
  logic        pwm_cycle_i = 0, parking_end_i = 0, offset_done_i = 0;
  logic [11:0] thermistor_voltage_i = 12'hFFF, cur_a = 0, cur_b = 0, cur_c = 0;
  logic [11:0] ofs_a = 0, ofs_b = 0, ofs_c = 0, comparator_trip_level_o;
  logic        pin_n, in_fault, pwm_trap_o, zero_vector_o, fault_state_req_o, stop_state_req_o;
  logic [31:0] acc;
  int          err_total = 0, tests_run = 0, n;
  reg_row_t    regs [10] = '{
    '{ADR_FLAGS, 16'h0000, 16'hFFFF, 16'h0000}, '{ADR_STATE, 16'h0000, 16'hFFFF, 16'h0000},
    '{ADR_VBUS, 16'h0000, 16'hFFFF, 16'h0000}, '{ADR_ENABLE, 16'h034C, 16'h0000, 16'h0000},
    '{ADR_CONFIG, 16'h0003, 16'h0005, 16'h0005}, '{ADR_DEBOUNCE, 16'h0060, 16'h0002, 16'h0004},
    '{ADR_OVLVL, 16'hFFFF, 16'h1234, 16'h1234}, '{ADR_CMPLVL, 16'h0FFF, 16'h1ABC, 16'h0FFF},
    '{ADR_OFSMAX, 16'h0FFF, 16'h0A00, 16'h0A00}, '{ADR_OFSMIN, 16'h0000, 16'h0600, 16'h0600}};
  trip_row_t   trips [6] = '{
    '{16'h0001, 1'b1, 3'b000, 16'h0021}, '{16'h0002, 1'b0, 3'b001, 16'h0001},
    '{16'h0002, 1'b0, 3'b010, 16'h0000}, '{16'h0006, 1'b0, 3'b100, 16'h0001},
    '{16'h0002, 1'b1, 3'b000, 16'h0000}, '{16'h0003, 1'b1, 3'b001, 16'h0021}};
  always #25 clk_i = ~clk_i;
  // ----------------------------------------
  // design and partner
  // ----------------------------------------
  motor_fault_protection motor_fault_protection_i (.clk_i(clk_i), .rstn_i(rstn_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .overcurrent_trip_pin_n_i(pin_n), .comparator_trip_i(comparator_trip_i),
    .pwm_cycle_i(pwm_cycle_i), .bus_voltage_i(bus_voltage_i),
    .thermistor_voltage_i(thermistor_voltage_i), .parking_end_i(parking_end_i),
    .phase_current_a_i(cur_a), .phase_current_b_i(cur_b), .phase_current_c_i(cur_c),
    .offset_done_i(offset_done_i), .offset_a_i(ofs_a), .offset_b_i(ofs_b),
    .offset_c_i(ofs_c), .motor_in_fault_i(in_fault), .pwm_trap_o(pwm_trap_o),
    .zero_vector_o(zero_vector_o), .fault_state_req_o(fault_state_req_o),
    .stop_state_req_o(stop_state_req_o), .comparator_trip_level_o(comparator_trip_level_o));
  fault_partner fault_partner_i (.clk_i(clk_i), .rstn_i(rstn_i), .trip_req_i(trip_req),
    .fault_state_req_i(fault_state_req_o), .overcurrent_trip_pin_n_o(pin_n),
    .motor_in_fault_o(in_fault));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic step(input int c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask : step
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    d = rdata_o;
  endtask : rd
  task automatic clear_all();
    wr(ADR_CLEAR, 16'h0001);
    step(3);
  endtask : clear_all
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    step(10);
    rstn_i <= 1'b1;
    step(2);
    foreach (regs[i]) begin
      rd(regs[i].a, rv);
      `CHK("reset value", regs[i].rv, rv)
      wr(regs[i].a, regs[i].wd);
      rd(regs[i].a, rv);
      `CHK("readback", regs[i].ex, rv)
    end
    `CHK("comparator level", 12'hFFF, comparator_trip_level_o)
    clear_all();
    foreach (trips[i]) begin
      wr(ADR_CONFIG, trips[i].cfg);
      trip_req          <= trips[i].pin;
      comparator_trip_i <= trips[i].cmp;
      step(20);
      rd(ADR_FLAGS, rv);
      `CHK("trip flags", trips[i].ex, rv)
      `CHK("trap", |trips[i].ex, pwm_trap_o)
      `CHK("unmasked trip req", |trips[i].ex, fault_state_req_o)
      trip_req          <= 1'b0;
      comparator_trip_i <= 3'b000;
      step(20);
      `CHK("trap latched", |trips[i].ex, pwm_trap_o)
      clear_all();
      `CHK("trap cleared", 1'b0, pwm_trap_o)
    end
    wr(ADR_CONFIG, 16'h0001);
    trip_req <= 1'b1;
    step(2);
    trip_req <= 1'b0;
    step(10);
    `CHK("glitch ignored", 1'b0, pwm_trap_o)
    wr(ADR_DEBOUNCE, 16'h03E8);
    rd(ADR_DEBOUNCE, rv);
    `CHK("debounce max", 16'h03C0, rv)
    wr(ADR_DEBOUNCE, 16'h0402);
    rd(ADR_DEBOUNCE, rv);
    `CHK("debounce wide", 16'h03C0, rv)
    wr(ADR_DEBOUNCE, 16'h0010);
    trip_req <= 1'b1;
    n = 0;
    while (pwm_trap_o !== 1'b1 && n < 100) begin
      step(1);
      n++;
    end
    `CHK("trip delay", 1'b1, n >= 16 && n <= 21)
    trip_req <= 1'b0;
    clear_all();
    wr(ADR_OVLVL, 16'h1000);
    wr(ADR_ENABLE, 16'h0004);
    clear_all();
    bus_voltage_i <= 16'h8000;
    acc = 32'h0000_0000;
    repeat (40) begin
      @(posedge clk_i);
      pwm_cycle_i <= 1'b1;
      @(posedge clk_i);
      pwm_cycle_i <= 1'b0;
      acc = acc - (acc >> 5) + 32'h0400_0000;
    end
    step(3);
    rd(ADR_VBUS, rv);
    `CHK("filtered bus", acc[31:16], rv)
    rd(ADR_FLAGS, rv);
    `CHK("ov flag", 16'h0004, rv)
    `CHK("ov req", 1'b1, fault_state_req_o)
    rd(ADR_ACTIVE, rv);
    `CHK("ov active", 16'h0004, rv)
    wr(ADR_ENABLE, 16'h0000);
    step(2);
    `CHK("ov masked", 1'b0, fault_state_req_o)
    rd(ADR_ACTIVE, rv);
    `CHK("ov active masked", 16'h0000, rv)
    wr(ADR_CRITLVL, 16'h2000);
    wr(ADR_UVLVL, 16'hF000);
    step(3);
    `CHK("zero vector", 1'b1, zero_vector_o)
    `CHK("crit req", 1'b1, fault_state_req_o)
    rd(ADR_FLAGS, rv);
    `CHK("uv flag", 1'b1, rv[FLT_UV_BIT])
    wr(ADR_CRITLVL, 16'hFFFF);
    wr(ADR_OVLVL, 16'hFFFF);
    wr(ADR_UVLVL, 16'h0000);
    step(3);
    `CHK("zero vector held", 1'b1, zero_vector_o)
    clear_all();
    `CHK("zero vector cleared", 1'b0, zero_vector_o)
    wr(ADR_ENABLE, 16'h0040);
    wr(ADR_OTLVL, 16'h0800);
    thermistor_voltage_i <= 12'h700;
    step(3);
    rd(ADR_FLAGS, rv);
    `CHK("ot flag", 16'h0040, rv)
    `CHK("ot req", 1'b1, fault_state_req_o)
    wr(ADR_ENABLE, 16'h0000);
    step(2);
    `CHK("ot masked", 1'b0, fault_state_req_o)
    thermistor_voltage_i <= 12'hFFF;
    clear_all();
    wr(ADR_PLLVL, 16'h0100);
    wr(ADR_ENABLE, 16'h0100);
    for (int k = 0; k < 2; k++) begin
      cur_a <= 12'h200;
      cur_b <= (k == 0) ? 12'h050 : 12'h200;
      cur_c <= 12'h200;
      @(posedge clk_i);
      parking_end_i <= 1'b1;
      @(posedge clk_i);
      parking_end_i <= 1'b0;
      step(3);
      rd(ADR_FLAGS, rv);
      `CHK("phase loss", (k == 0) ? 16'h0100 : 16'h0000, rv)
      `CHK("phase loss req", k == 0, fault_state_req_o)
      clear_all();
    end
    wr(ADR_ENABLE, 16'h0000);
    ofs_a <= 12'h800;
    ofs_b <= 12'hB00;
    ofs_c <= 12'h800;
    @(posedge clk_i);
    offset_done_i <= 1'b1;
    @(posedge clk_i);
    offset_done_i <= 1'b0;
    step(3);
    rd(ADR_FLAGS, rv);
    `CHK("offset flag", 16'h0200, rv)
    `CHK("offset stop", 1'b1, stop_state_req_o)
    `CHK("offset no fault", 1'b0, fault_state_req_o)
    rd(ADR_STATE, rv);
    `CHK("offset state", 16'h0008, rv)
    clear_all();
    rd(ADR_FLAGS, rv);
    `CHK("offset kept", 16'h0200, rv)
    wr(ADR_ENABLE, 16'h0200);
    step(3);
    `CHK("offset fault", 1'b1, fault_state_req_o)
    clear_all();
    rd(ADR_FLAGS, rv);
    `CHK("offset cleared", 16'h0000, rv)
    wr(ADR_ENABLE, 16'h0040);
    wr(ADR_OTLVL, 16'h0800);
    thermistor_voltage_i <= 12'h700;
    step(3);
    `CHK("ot before reset", 1'b1, fault_state_req_o)
    rstn_i <= 1'b0;
    step(2);
    `CHK("req in reset", 1'b0, fault_state_req_o)
    `CHK("rdata in reset", 16'h0000, rdata_o)
    rstn_i <= 1'b1;
    thermistor_voltage_i <= 12'hFFF;
    step(2);
    rd(ADR_DEBOUNCE, rv);
    `CHK("debounce after reset", 16'h0060, rv)
    rd(ADR_FLAGS, rv);
    `CHK("flags after reset", 16'h0000, rv)
    finish_test();
  end
endmodule : motor_fault_protection_test
